// *** apr_pkg.sv ***
/*
 * apr_pkg: constants, register map, field layout and state encodings of
 * the absolute power-up position reader.
 * assumes a 125 MHz ref_clk; every timing count is derived from it here.
 */
package apr_pkg;
    // timing
    localparam int          CLK_NS     = 8;
    localparam int          SETTLE_NS  = 1000;
    localparam int          HALF_NS    = 200;
    // least settle time rounds up, serial half period rounds up as well
    localparam logic [15:0] SETTLE_CYC = 16'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] HALF_CYC   = 16'((HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] CNT_ONE    = 16'h0001;

    // resolver word
    localparam int          RES_W      = 12;
    localparam logic [3:0]  RES_LAST   = 4'hB;
    localparam logic [47:0] RES_COUNTS = 48'h000000001000;
    localparam logic [47:0] RES_HALF   = 48'h000000000800;

    // position and parallel words
    localparam int          POS_W      = 48;
    localparam int          WORD_W     = 24;
    localparam int          RATIO_W    = 12;

    // configuration word fields
    localparam int          CFG_SIGN   = 23;
    localparam int          CFG_XSPACE = 22;
    localparam int          CNT_LSB    = 16;
    localparam int          CNT_MSB    = 21;
    localparam int          LOC_LSB    = 16;
    localparam int          LOC_MSB    = 18;
    localparam int          ADR_MSB    = 15;
    localparam logic [5:0]  PAR_MIN    = 6'h08;
    localparam logic [5:0]  PAR_MAX    = 6'h30;
    localparam logic [5:0]  PAR_ONE_WD = 6'h18;
    localparam logic [15:0] MUX0_CODE  = 16'h0100;

    // register byte offsets
    localparam logic [7:0]  ADR_CFG    = 8'h00;
    localparam logic [7:0]  ADR_RAT2   = 8'h04;
    localparam logic [7:0]  ADR_RAT3   = 8'h08;
    localparam logic [7:0]  ADR_PHCFG  = 8'h0C;
    localparam logic [7:0]  ADR_CTRL   = 8'h10;
    localparam logic [7:0]  ADR_STAT   = 8'h14;
    localparam logic [7:0]  ADR_POSLO  = 8'h18;
    localparam logic [7:0]  ADR_POSHI  = 8'h1C;
    localparam logic [7:0]  ADR_PHPOS  = 8'h20;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_PAR0  = 7'h02,
        ST_PAR1  = 7'h04,
        ST_RES   = 7'h08,
        ST_COMB  = 7'h10,
        ST_PHASE = 7'h20,
        ST_DONE  = 7'h40
    } apr_state_t;

    typedef enum logic [3:0] {
        SR_IDLE   = 4'h1,
        SR_SETTLE = 4'h2,
        SR_LOW    = 4'h4,
        SR_HIGH   = 4'h8
    } apr_ser_t;
endpackage

// *** apr_ser_rx.sv ***
/*
 * apr_ser_rx: waits for the multiplexed serial line to settle, then clocks
 * in one 12-bit converter word, msb first, sampled at each ser_clk rise.
 * assumes the caller holds mux address and converter location steady
 * from the start pulse until done.
 */
`timescale 1ns/10ps
module apr_ser_rx
    import apr_pkg::*;
(
    // clock, reset, enable
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // control
    input  wire logic             start,
    output logic                  done,
    output logic [RES_W-1:0]      data,
    // serial line
    output logic                  ser_clk,
    input  wire logic             ser_data
);
    apr_ser_t          st_r,   st_nxt;
    logic [15:0]       cnt_r,  cnt_nxt;
    logic [3:0]        bit_r,  bit_nxt;
    logic [RES_W-1:0]  sh_r,   sh_nxt;
    logic              done_r, done_nxt;

    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        bit_nxt  = bit_r;
        sh_nxt   = sh_r;
        done_nxt = 1'b0;
        case (st_r)
            SR_IDLE: begin
                if (start) begin
                    st_nxt  = SR_SETTLE;
                    cnt_nxt = SETTLE_CYC;
                    bit_nxt = 4'h0;
                end
            end
            SR_SETTLE, SR_HIGH: begin
                if (cnt_r > CNT_ONE) begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end else if (st_r == SR_HIGH && bit_r == RES_LAST) begin
                    st_nxt   = SR_IDLE;
                    done_nxt = 1'b1;
                end else begin
                    st_nxt  = SR_LOW;
                    cnt_nxt = HALF_CYC;
                    if (st_r == SR_HIGH) begin
                        bit_nxt = bit_r + 4'h1;
                    end
                end
            end
            SR_LOW: begin
                if (cnt_r > CNT_ONE) begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end else begin
                    st_nxt  = SR_HIGH;
                    cnt_nxt = HALF_CYC;
                    sh_nxt  = {sh_r[RES_W-2:0], ser_data};
                end
            end
            default: st_nxt = SR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_r   <= SR_IDLE;
            cnt_r  <= 16'h0000;
            bit_r  <= 4'h0;
            sh_r   <= 12'h000;
            done_r <= 1'b0;
        end else if (ce) begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            bit_r  <= bit_nxt;
            sh_r   <= sh_nxt;
            done_r <= done_nxt;
        end
    end

    assign done    = done_r;
    assign data    = sh_r;
    assign ser_clk = (st_r == SR_HIGH);

    property p_settle;
        @(posedge ref_clk) disable iff (!nrst)
        (start && st_r == SR_IDLE) |=> !done_r [*8];
    endproperty
    a_settle: assert property (p_settle) else $error("word ended early");
endmodule

// *** apr_reader.sv ***
/*
 * apr_reader: one-shot absolute position read after reset, from a parallel
 * register source or from up to three geared resolver converters, with an
 * optional phase position read; registers over an ahb-lite slave.
 * assumes one ahb master, whole-word transfers, and a parallel source that
 * answers each par_rd with par_ack in some later cycle.
 */
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module apr_reader
    import apr_pkg::*;
(
    // clock, reset, enable
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    // ahb-lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    // parallel source
    output logic                    par_rd,
    output logic                    par_space_x,
    output logic [15:0]             par_addr,
    input  wire logic               par_ack,
    input  wire logic [WORD_W-1:0]  par_data,
    // resolver port
    output logic                    mux_sel,
    output logic [7:0]              mux_addr,
    output logic [2:0]              conv_loc,
    output logic                    ser_clk,
    input  wire logic               ser_data,
    // results
    output logic [POS_W-1:0]        abs_pos,
    output logic                    abs_pos_valid,
    output logic [RES_W-1:0]        phase_pos,
    output logic                    phase_valid,
    output logic                    read_busy
);
    apr_state_t          st_r,    st_nxt;
    logic [23:0]         cfg_r,   cfg_nxt;
    logic [23:0]         phc_r,   phc_nxt;
    logic [RATIO_W-1:0]  rat2_r,  rat2_nxt;
    logic [RATIO_W-1:0]  rat3_r,  rat3_nxt;
    logic [1:0]          idx_r,   idx_nxt;
    logic [RES_W-1:0]    res_r    [3];
    logic [RES_W-1:0]    res_nxt  [3];
    logic [POS_W-1:0]    raw_r,   raw_nxt;
    logic [POS_W-1:0]    pos_r,   pos_nxt;
    logic [RES_W-1:0]    ph_r,    ph_nxt;
    logic                pvld_r,  pvld_nxt;
    logic                hvld_r,  hvld_nxt;
    logic                wpend_r, wpend_nxt;
    logic [7:0]          waddr_r, waddr_nxt;
    logic [31:0]         rdat_r,  rdat_nxt;
    logic                ser_start;
    logic                ser_done;
    logic [RES_W-1:0]    ser_q;
    logic                arm;
    logic                is_res;
    logic [5:0]          nbits;

    // turns count from the coarse estimate, fine word kept as-is
    function automatic logic [POS_W-1:0] gear_join(
        input logic [POS_W-1:0] coarse,
        input logic [RES_W-1:0] fine
    );
        logic [POS_W-1:0] t;
        t = coarse + RES_HALF - {36'h000000000, fine};
        return {t[POS_W-1:RES_W], fine};
    endfunction

    function automatic logic [7:0] mux_of(input logic [15:0] code);
        return (code == MUX0_CODE) ? 8'h00 : code[7:0];
    endfunction

    function automatic logic [POS_W-1:0] wide(input logic [RES_W-1:0] v);
        return {36'h000000000, v};
    endfunction

    assign is_res = (cfg_r[ADR_MSB:0] <= MUX0_CODE);
    assign nbits  = (cfg_r[CNT_MSB:CNT_LSB] < PAR_MIN) ? PAR_MIN :
                    (cfg_r[CNT_MSB:CNT_LSB] > PAR_MAX) ? PAR_MAX :
                    cfg_r[CNT_MSB:CNT_LSB];
    // a second arm after the first read is ignored until reset
    assign arm = wpend_r && waddr_r == ADR_CTRL && hwdata[0]
                 && st_r == ST_IDLE;

    always_comb begin
        logic [POS_W-1:0] v;
        logic [POS_W-1:0] rng;
        logic [POS_W-1:0] c23;
        v         = 48'h000000000000;
        rng       = RES_COUNTS;
        c23       = 48'h000000000000;
        st_nxt    = st_r;
        idx_nxt   = idx_r;
        res_nxt   = res_r;
        raw_nxt   = raw_r;
        pos_nxt   = pos_r;
        ph_nxt    = ph_r;
        pvld_nxt  = pvld_r;
        hvld_nxt  = hvld_r;
        ser_start = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (arm && cfg_r == 24'h000000) begin
                    pos_nxt  = 48'h000000000000;
                    pvld_nxt = 1'b1;
                    st_nxt   = (phc_r != 24'h000000) ? ST_PHASE : ST_DONE;
                    ser_start = (phc_r != 24'h000000);
                end else if (arm && is_res) begin
                    st_nxt    = ST_RES;
                    idx_nxt   = 2'h0;
                    ser_start = 1'b1;
                end else if (arm) begin
                    st_nxt = ST_PAR0;
                end
            end
            ST_PAR0: begin
                if (par_ack) begin
                    raw_nxt = {24'h000000, par_data};
                    st_nxt  = (nbits > PAR_ONE_WD) ? ST_PAR1 : ST_COMB;
                end
            end
            ST_PAR1: begin
                if (par_ack) begin
                    raw_nxt = {par_data, raw_r[WORD_W-1:0]};
                    st_nxt  = ST_COMB;
                end
            end
            ST_RES: begin
                if (ser_done) begin
                    res_nxt[idx_r] = ser_q;
                    if ((idx_r == 2'h0 && rat2_r != 12'h000) ||
                        (idx_r == 2'h1 && rat3_r != 12'h000)) begin
                        idx_nxt   = idx_r + 2'h1;
                        ser_start = 1'b1;
                    end else begin
                        st_nxt = ST_COMB;
                    end
                end
            end
            ST_COMB: begin
                if (!is_res) begin
                    v = raw_r & ((48'h000000000001 << nbits)
                                 - 48'h000000000001);
                    if (cfg_r[CFG_SIGN] && v[nbits - 6'h01]) begin
                        v = v - (48'h000000000001 << nbits);
                    end
                end else begin
                    if (rat2_r == 12'h000) begin
                        v = wide(res_r[0]);
                    end else if (rat3_r == 12'h000) begin
                        v   = gear_join(48'(wide(res_r[1])
                                            * wide(rat2_r)), res_r[0]);
                        rng = 48'(RES_COUNTS * wide(rat2_r));
                    end else begin
                        c23 = gear_join(48'(wide(res_r[2])
                                            * wide(rat3_r)), res_r[1]);
                        v   = gear_join(48'(c23 * wide(rat2_r)), res_r[0]);
                        rng = 48'(RES_COUNTS * wide(rat2_r)
                                  * wide(rat3_r));
                    end
                    if (v >= rng) begin
                        v = v - rng;
                    end
                    if (cfg_r[CFG_SIGN] && v >= (rng >> 1)) begin
                        v = v - rng;
                    end
                end
                // counters restart at zero; this is the offset to them
                pos_nxt   = v;
                pvld_nxt  = 1'b1;
                st_nxt    = (phc_r != 24'h000000) ? ST_PHASE : ST_DONE;
                ser_start = (phc_r != 24'h000000);
            end
            ST_PHASE: begin
                if (ser_done) begin
                    ph_nxt   = ser_q;
                    hvld_nxt = 1'b1;
                    st_nxt   = ST_DONE;
                end
            end
            ST_DONE: st_nxt = ST_DONE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    // bus side: address phase latched, write data taken in the data phase
    always_comb begin
        wpend_nxt = 1'b0;
        waddr_nxt = waddr_r;
        rdat_nxt  = rdat_r;
        cfg_nxt   = cfg_r;
        phc_nxt   = phc_r;
        rat2_nxt  = rat2_r;
        rat3_nxt  = rat3_r;
        // configuration freezes once a read is under way
        if (wpend_r && st_r == ST_IDLE) begin
            if (waddr_r == ADR_CFG) begin
                cfg_nxt = hwdata[23:0];
            end else if (waddr_r == ADR_RAT2) begin
                rat2_nxt = hwdata[RATIO_W-1:0];
            end else if (waddr_r == ADR_RAT3) begin
                rat3_nxt = hwdata[RATIO_W-1:0];
            end else if (waddr_r == ADR_PHCFG) begin
                phc_nxt = hwdata[23:0];
            end
        end
        if (hsel && htrans[1] && hready) begin
            wpend_nxt = hwrite;
            waddr_nxt = haddr[7:0];
            if (haddr[7:0] == ADR_CFG) begin
                rdat_nxt = {8'h00, cfg_r};
            end else if (haddr[7:0] == ADR_RAT2) begin
                rdat_nxt = {20'h00000, rat2_r};
            end else if (haddr[7:0] == ADR_RAT3) begin
                rdat_nxt = {20'h00000, rat3_r};
            end else if (haddr[7:0] == ADR_PHCFG) begin
                rdat_nxt = {8'h00, phc_r};
            end else if (haddr[7:0] == ADR_STAT) begin
                rdat_nxt = {28'h0000000, hvld_r, pvld_r,
                            st_r == ST_DONE, read_busy};
            end else if (haddr[7:0] == ADR_POSLO) begin
                rdat_nxt = pos_r[31:0];
            end else if (haddr[7:0] == ADR_POSHI) begin
                rdat_nxt = {16'h0000, pos_r[POS_W-1:32]};
            end else if (haddr[7:0] == ADR_PHPOS) begin
                rdat_nxt = {20'h00000, ph_r};
            end else begin
                rdat_nxt = 32'h00000000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_r    <= ST_IDLE;
            cfg_r   <= 24'h000000;
            phc_r   <= 24'h000000;
            rat2_r  <= 12'h000;
            rat3_r  <= 12'h000;
            idx_r   <= 2'h0;
            res_r   <= '{3{12'h000}};
            raw_r   <= 48'h000000000000;
            pos_r   <= 48'h000000000000;
            ph_r    <= 12'h000;
            pvld_r  <= 1'b0;
            hvld_r  <= 1'b0;
            wpend_r <= 1'b0;
            waddr_r <= 8'h00;
            rdat_r  <= 32'h00000000;
        end else if (ce) begin
            st_r    <= st_nxt;
            cfg_r   <= cfg_nxt;
            phc_r   <= phc_nxt;
            rat2_r  <= rat2_nxt;
            rat3_r  <= rat3_nxt;
            idx_r   <= idx_nxt;
            res_r   <= res_nxt;
            raw_r   <= raw_nxt;
            pos_r   <= pos_nxt;
            ph_r    <= ph_nxt;
            pvld_r  <= pvld_nxt;
            hvld_r  <= hvld_nxt;
            wpend_r <= wpend_nxt;
            waddr_r <= waddr_nxt;
            rdat_r  <= rdat_nxt;
        end
    end

    apr_ser_rx u_ser (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .ce       (ce),
        .start    (ser_start),
        .done     (ser_done),
        .data     (ser_q),
        .ser_clk  (ser_clk),
        .ser_data (ser_data)
    );

    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = rdat_r;
    assign par_rd        = (st_r == ST_PAR0) || (st_r == ST_PAR1);
    assign par_space_x   = cfg_r[CFG_XSPACE];
    assign par_addr      = (st_r == ST_PAR1) ? cfg_r[ADR_MSB:0] + 16'h0001
                                             : cfg_r[ADR_MSB:0];
    assign mux_sel       = (st_r == ST_RES) || (st_r == ST_PHASE);
    assign mux_addr      = (st_r == ST_PHASE) ? mux_of(phc_r[ADR_MSB:0])
                                              : mux_of(cfg_r[ADR_MSB:0]);
    assign conv_loc      = (st_r == ST_PHASE) ? phc_r[LOC_MSB:LOC_LSB]
                           : cfg_r[LOC_MSB:LOC_LSB] + {1'b0, idx_r};
    assign abs_pos       = pos_r;
    assign abs_pos_valid = pvld_r;
    assign phase_pos     = ph_r;
    assign phase_valid   = hvld_r;
    assign read_busy     = (st_r != ST_IDLE) && (st_r != ST_DONE);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_zero;
        $rose(pvld_r) && cfg_r == 24'h000000 |-> pos_r == 48'h000000000000;
    endproperty
    a_zero: assert property (p_zero) else $error("zero word gave nonzero");
    property p_once;
        st_r == ST_DONE |=> st_r == ST_DONE && pvld_r;
    endproperty
    a_once: assert property (p_once) else $error("read restarted");
    property p_par_addr;
        st_r == ST_PAR0 |-> par_rd && par_addr == cfg_r[ADR_MSB:0];
    endproperty
    a_par_addr: assert property (p_par_addr) else $error("bad par addr");
    property p_par_next;
        st_r == ST_PAR1 |-> par_addr == cfg_r[ADR_MSB:0] + 16'h0001
                            && nbits > PAR_ONE_WD;
    endproperty
    a_par_next: assert property (p_par_next) else $error("bad 2nd addr");
    property p_space;
        par_rd |-> par_space_x == cfg_r[CFG_XSPACE];
    endproperty
    a_space: assert property (p_space) else $error("wrong space");
    property p_mux0;
        st_r == ST_RES && cfg_r[ADR_MSB:0] == MUX0_CODE |-> mux_addr == 8'h00;
    endproperty
    a_mux0: assert property (p_mux0) else $error("mux code 256 wrong");
    property p_loc;
        st_r == ST_RES |-> conv_loc == cfg_r[LOC_MSB:LOC_LSB] + {1'b0, idx_r};
    endproperty
    a_loc: assert property (p_loc) else $error("wrong location");
    property p_range;
        $rose(pvld_r) && is_res && cfg_r != 24'h000000 && rat2_r == 12'h000
        |-> cfg_r[CFG_SIGN] ? (pos_r < 48'h000000000800 ||
                               pos_r >= 48'hFFFFFFFFF800)
                            : pos_r < 48'h000000001000;
    endproperty
    a_range: assert property (p_range) else $error("resolver range");
    property p_settle_mux;
        $rose(mux_sel) |-> mux_sel [*8];
    endproperty
    a_settle_mux: assert property (p_settle_mux) else $error("mux dropped");

    c_par:   cover property (st_r == ST_PAR1 && par_ack);
    c_res1:  cover property ($rose(pvld_r) && is_res && rat2_r == 12'h000);
    c_res3:  cover property ($rose(pvld_r) && rat3_r != 12'h000 && is_res);
    c_phase: cover property ($rose(hvld_r));
endmodule

// *** apr_far_model.sv ***
/*
 * apr_far_model: parallel source board and serial converter board.
 * assumes ser_clk idles low and mux lines hold while mux_sel is high.
 */
`timescale 1ns/10ps
module apr_far_model
    import apr_pkg::*;
(
    // parallel source
    input  wire logic              ref_clk,
    input  wire logic              par_rd,
    input  wire logic              par_space_x,
    input  wire logic [15:0]       par_addr,
    output logic                   par_ack,
    output logic [WORD_W-1:0]      par_data,
    // converter port
    input  wire logic              mux_sel,
    input  wire logic [7:0]        mux_addr,
    input  wire logic [2:0]        conv_loc,
    input  wire logic              ser_clk,
    output logic                   ser_data
);
    logic [2:0]  cnt = 3'h0;
    logic [3:0]  idx = 4'hB;
    logic        tgl = 1'b0;
    logic [23:0] pword;
    logic [11:0] sword;
    // the word names the space and address asked for
    assign pword = {7'h52, par_space_x, par_addr};
    // released lines carry the inverse, never the last value
    assign par_data = par_ack ? pword : ~pword;
    assign sword = {1'b1, mux_addr[2:0], 5'h00, conv_loc};
    assign ser_data = (mux_sel && idx < 4'hC) ? sword[idx] : tgl;
    // odd addresses answer slowly, even ones promptly
    always @(posedge ref_clk) begin
        tgl <= ~tgl;
        par_ack <= 1'b0;
        cnt <= 3'h0;
        if (par_rd && !par_ack) begin
            if (cnt == (par_addr[0] ? 3'h5 : 3'h1)) begin
                par_ack <= 1'b1;
            end else begin
                cnt <= cnt + 3'h1;
            end
        end
    end
    // the count wraps after the lsb so geared words follow on directly
    always @(negedge ser_clk) begin
        idx <= (idx == 4'h0) ? 4'hB : idx - 4'h1;
    end
endmodule

// *** testbench.sv ***
/*
 * testbench: one absolute read per reset over the ahb-lite registers.
 * assumes apr_far_model on the far side and a zero-wait slave.
 */
`timescale 1ns/10ps
module testbench;
    import apr_pkg::*;
    logic              ref_clk = 1'b0;
    logic              nrst = 1'b0;
    logic              hsel = 1'b0;
    logic [31:0]       haddr = 32'h0;
    logic [1:0]        htrans = 2'h0;
    logic              hwrite = 1'b0;
    logic [31:0]       hwdata = 32'h0;
    logic              hready, hreadyout, hresp;
    logic [31:0]       hrdata, q;
    logic              par_rd, par_space_x, par_ack;
    logic [15:0]       par_addr;
    logic [WORD_W-1:0] par_data;
    logic              mux_sel, ser_clk, ser_data;
    logic [7:0]        mux_addr;
    logic [2:0]        conv_loc;
    logic [POS_W-1:0]  abs_pos;
    logic [RES_W-1:0]  phase_pos;
    logic              abs_pos_valid, phase_valid, read_busy;
    int                mismatches = 0;
    int                checks_done = 0;
    int                n;
    // readings sit clear of the sensor rollover points
    logic [23:0] cfgs [7] = '{24'h000000, 24'h16FFD1, 24'h56FFD1,
                              24'hA0FFD0, 24'h830002, 24'h000100,
                              24'h000004};
    logic [31:0] exlo [7] = '{32'h0, 32'h0024FFD1, 32'h0025FFD1,
                              32'hD1A4FFD0, 32'hFFFFFA03, 32'h00000800,
                              32'h00003C00};
    logic [31:0] exhi [7] = '{32'h0, 32'h0, 32'h0,
                              32'h0000FFFF, 32'h0000FFFF, 32'h0, 32'h0};
    assign hready = hreadyout;
    always #4 ref_clk = ~ref_clk;
    apr_reader uut (.ref_clk, .nrst, .ce(1'b1), .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp,
        .hrdata, .par_rd, .par_space_x, .par_addr, .par_ack, .par_data,
        .mux_sel, .mux_addr, .conv_loc, .ser_clk, .ser_data, .abs_pos,
        .abs_pos_valid, .phase_pos, .phase_valid, .read_busy);
    apr_far_model far (.ref_clk, .par_rd, .par_space_x, .par_addr,
        .par_ack, .par_data, .mux_sel, .mux_addr, .conv_loc, .ser_clk,
        .ser_data);
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int k = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge ref_clk);
        while (hready !== 1'b1 && k < 50) begin
            @(posedge ref_clk);
            k++;
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hready !== 1'b1 && k < 100) begin
            @(posedge ref_clk);
            k++;
        end
        r = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #240000;
        mismatches++;
        close_out();
    end
    initial begin
        for (int i = 0; i < 7; i++) begin
            nrst <= 1'b0;
            repeat (8) @(posedge ref_clk);
            nrst <= 1'b1;
            @(posedge ref_clk);
            bus(1'b1, ADR_CFG, {8'h00, cfgs[i]}, q);
            bus(1'b0, ADR_CFG, 32'h0, q);
            chk(q, {8'h00, cfgs[i]});
            // last test: three geared resolvers plus a phase read
            if (i == 6) begin
                bus(1'b1, ADR_RAT2, 32'h2, q);
                bus(1'b1, ADR_RAT3, 32'h2, q);
                bus(1'b1, ADR_PHCFG, 32'h00050006, q);
                bus(1'b0, ADR_RAT3, 32'h0, q);
                chk(q, 32'h2);
            end
            bus(1'b1, ADR_CTRL, 32'h1, q);
            n = 0;
            while (abs_pos_valid !== 1'b1 && n < 3000) begin
                @(posedge ref_clk);
                n++;
            end
            chk({31'h0, abs_pos_valid}, 32'h1);
            bus(1'b0, ADR_POSLO, 32'h0, q);
            chk(q, exlo[i]);
            chk(abs_pos[31:0], exlo[i]);
            bus(1'b0, ADR_POSHI, 32'h0, q);
            chk(q, exhi[i]);
            if (i == 6) begin
                n = 0;
                while (phase_valid !== 1'b1 && n < 3000) begin
                    @(posedge ref_clk);
                    n++;
                end
                bus(1'b0, ADR_PHPOS, 32'h0, q);
                chk(q, 32'h00000E05);
                chk({20'h00000, phase_pos}, 32'h00000E05);
            end
            // a second arm must not start another read
            bus(1'b1, ADR_CTRL, 32'h1, q);
            repeat (2) @(posedge ref_clk);
            chk({31'h0, read_busy}, 32'h0);
            bus(1'b0, ADR_STAT, 32'h0, q);
            chk(q, (i == 6) ? 32'h0000000E : 32'h00000006);
            $display("test %0d done", i);
        end
        close_out();
    end
endmodule
